//--- design/lpsm_pkg.sv
// package for the low-power state and system-management entry block
// assumes a single bus clock domain; request pins arrive asynchronously
package lpsm_pkg;
  // synchroniser depth for asynchronous request pins
  localparam int SYNC_STAGES = 3;
  // power state encoding
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_GRANT = 2'h1,
    ST_SLEEP = 2'h2
  } lpsm_state_t;
  // acknowledge transaction kinds on the bus request port
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_GRANT = 2'h1;
  localparam logic [1:0] ACK_SMI = 2'h2;
  // clock gate bit positions in the unit enable vector
  localparam int GATE_CORE = 0;
  localparam int GATE_BUS = 1;
  localparam int GATE_INTR = 2;
  localparam int GATE_W = 3;
  // smm entry sequence encoding
  typedef enum logic [1:0] {
    SM_IDLE = 2'h0,
    SM_SAVE = 2'h1,
    SM_ACK = 2'h2,
    SM_FETCH = 2'h3
  } lpsm_smm_t;
endpackage : lpsm_pkg

//--- design/lpsm_top.sv
// power-state and system-management entry control for a processor core
// assumes chipset pins are asynchronous, active low; the bus clock
// sys_clk is never gated by this block and keeps running in every state
//
// Function
// - an asserted clock-halt request moves the processor into the grant state.
// - entering the grant state from run issues one grant acknowledge bus transaction.
// - in the grant state only the bus and interrupt-controller clocks run.
// - in the grant state snooping and interrupt service stay enabled.
// - releasing the clock-halt request restarts all clocks and resumes.
// - the clock-halt request is asynchronous and never touches the bus clock.
// - a sleep request seen in the grant state moves the processor to sleep.
// - in sleep every unit clock stops and only the loop stays running.
// - in sleep snoops are not answered and interrupts are not recognised.
// - in sleep only sleep and reset inputs change state; a management interrupt is only held pending.
// - releasing sleep returns to grant and restarts bus and intr clocks.
// - an accepted management interrupt saves state and enters smm.
// - after acceptance a management acknowledge bus transaction issues.
// - after the acknowledge, fetching starts from the smm handler.
`timescale 1ns/1ps
module lpsm_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // chipset request pins, asynchronous
  input wire logic clock_halt_request_n,
  input wire logic sleep_request_n,
  input wire logic sys_mgmt_irq_n,
  // core handshakes
  input wire logic save_done,
  input wire logic ack_accepted,
  // bus acknowledge request
  output logic ack_valid,
  output logic [1:0] ack_kind,
  // unit clock enables and service enables
  output logic [lpsm_pkg::GATE_W-1:0] unit_clk_en,
  output logic pll_run,
  output logic snoop_en,
  output logic intr_en,
  output logic exec_en,
  // smm sequencing
  output logic save_state_req,
  output logic sys_mgmt_mode,
  output logic smm_fetch_start
);

  // three-flop synchronisers; a change counts once stages 2 and 3 agree
  logic [2:0] halt_sync_r, sleep_sync_r, smi_sync_r;
  logic [2:0] halt_sync_nxt, sleep_sync_nxt, smi_sync_nxt;
  logic halt_q_r, sleep_q_r, smi_q_r;
  logic halt_q_nxt, sleep_q_nxt, smi_q_nxt;

  // filtered value follows only when the last two stages agree
  function automatic logic settle(input logic [2:0] s, input logic q);
    settle = (s[2] == s[1]) ? s[2] : q;
  endfunction : settle

  // shift in inverted pins so the filtered level is active high
  always_comb begin
    halt_sync_nxt = {halt_sync_r[1:0], ~clock_halt_request_n};
    sleep_sync_nxt = {sleep_sync_r[1:0], ~sleep_request_n};
    smi_sync_nxt = {smi_sync_r[1:0], ~sys_mgmt_irq_n};
    halt_q_nxt = settle(halt_sync_r, halt_q_r);
    sleep_q_nxt = settle(sleep_sync_r, sleep_q_r);
    smi_q_nxt = settle(smi_sync_r, smi_q_r);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      halt_sync_r <= 3'h0;
      sleep_sync_r <= 3'h0;
      smi_sync_r <= 3'h0;
      halt_q_r <= 1'b0;
      sleep_q_r <= 1'b0;
      smi_q_r <= 1'b0;
    end else begin
      halt_sync_r <= halt_sync_nxt;
      sleep_sync_r <= sleep_sync_nxt;
      smi_sync_r <= smi_sync_nxt;
      halt_q_r <= halt_q_nxt;
      sleep_q_r <= sleep_q_nxt;
      smi_q_r <= smi_q_nxt;
    end
  end

  // power state machine and pending acknowledges
  lpsm_pkg::lpsm_state_t state_r, state_nxt;
  lpsm_pkg::lpsm_smm_t smm_r, smm_nxt;
  logic grant_ack_pend_r, grant_ack_pend_nxt;
  logic smi_prev_r, smi_prev_nxt;
  logic smi_pend_r, smi_pend_nxt;
  logic smm_mode_r, smm_mode_nxt;
  logic fetch_r, fetch_nxt;
  logic grant_ack_go, smi_ack_go;

  // only one acknowledge is offered at a time; grant goes first because
  // the core is already quiescing when it is pending
  assign grant_ack_go = grant_ack_pend_r;
  // the management ack is held back while asleep: the bus unit clock is off
  assign smi_ack_go = !grant_ack_pend_r && smm_r == lpsm_pkg::SM_ACK &&
                      state_r != lpsm_pkg::ST_SLEEP;

  always_comb begin
    state_nxt = state_r;
    grant_ack_pend_nxt = grant_ack_pend_r;
    if (grant_ack_go && ack_accepted) begin
      grant_ack_pend_nxt = 1'b0;
    end
    unique case (state_r)
      lpsm_pkg::ST_RUN: begin
        // sleep is not looked at here, so it cannot skip the grant state
        if (halt_q_r) begin
          state_nxt = lpsm_pkg::ST_GRANT;
          grant_ack_pend_nxt = 1'b1;
        end
      end
      lpsm_pkg::ST_GRANT: begin
        if (!halt_q_r) begin
          state_nxt = lpsm_pkg::ST_RUN;
          grant_ack_pend_nxt = 1'b0;
        end else if (sleep_q_r && !grant_ack_pend_r) begin
          state_nxt = lpsm_pkg::ST_SLEEP;
        end
      end
      lpsm_pkg::ST_SLEEP: begin
        // only sleep is examined, clock-halt is not; reset is asynchronous
        if (!sleep_q_r) begin
          state_nxt = lpsm_pkg::ST_GRANT;
        end
      end
      default: state_nxt = lpsm_pkg::ST_RUN;
    endcase
  end

  // smm entry: edge of the filtered request, held pending until serviced;
  // it is not recognised while asleep and waits until sleep ends
  always_comb begin
    smm_nxt = smm_r;
    smi_prev_nxt = smi_q_r;
    smi_pend_nxt = smi_pend_r;
    smm_mode_nxt = smm_mode_r;
    fetch_nxt = 1'b0;
    if (smi_q_r && !smi_prev_r) begin
      smi_pend_nxt = 1'b1;
    end
    unique case (smm_r)
      lpsm_pkg::SM_IDLE: begin
        if (smi_pend_r && state_r != lpsm_pkg::ST_SLEEP) begin
          smi_pend_nxt = smi_q_r && !smi_prev_r;
          smm_nxt = lpsm_pkg::SM_SAVE;
          smm_mode_nxt = 1'b1;
        end
      end
      lpsm_pkg::SM_SAVE: begin
        if (save_done && state_r != lpsm_pkg::ST_SLEEP) begin
          smm_nxt = lpsm_pkg::SM_ACK;
        end
      end
      lpsm_pkg::SM_ACK: begin
        if (smi_ack_go && ack_accepted) begin
          smm_nxt = lpsm_pkg::SM_FETCH;
        end
      end
      lpsm_pkg::SM_FETCH: begin
        fetch_nxt = 1'b1;
        smm_nxt = lpsm_pkg::SM_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= lpsm_pkg::ST_RUN;
      smm_r <= lpsm_pkg::SM_IDLE;
      grant_ack_pend_r <= 1'b0;
      smi_prev_r <= 1'b0;
      smi_pend_r <= 1'b0;
      smm_mode_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      smm_r <= smm_nxt;
      grant_ack_pend_r <= grant_ack_pend_nxt;
      smi_prev_r <= smi_prev_nxt;
      smi_pend_r <= smi_pend_nxt;
      smm_mode_r <= smm_mode_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  // acknowledge request toward the bus unit
  always_comb begin
    ack_valid = grant_ack_go || smi_ack_go;
    ack_kind = grant_ack_go ? lpsm_pkg::ACK_GRANT :
               smi_ack_go ? lpsm_pkg::ACK_SMI : lpsm_pkg::ACK_NONE;
  end

  // unit clocks and service enables by state; the loop always runs
  always_comb begin
    unit_clk_en = '1;
    snoop_en = 1'b1;
    intr_en = 1'b1;
    exec_en = 1'b1;
    pll_run = 1'b1;
    unique case (state_r)
      lpsm_pkg::ST_RUN: exec_en = 1'b1;
      lpsm_pkg::ST_GRANT: begin
        unit_clk_en[lpsm_pkg::GATE_CORE] = 1'b0;
        exec_en = 1'b0;
        snoop_en = 1'b1;
        intr_en = 1'b1;
      end
      lpsm_pkg::ST_SLEEP: begin
        unit_clk_en = '0;
        exec_en = 1'b0;
        snoop_en = 1'b0;
        intr_en = 1'b0;
      end
      default: unit_clk_en = '1;
    endcase
  end

  assign save_state_req = (smm_r == lpsm_pkg::SM_SAVE);
  assign sys_mgmt_mode = smm_mode_r;
  assign smm_fetch_start = fetch_r;

endmodule : lpsm_top

//--- tb/lpsm_top_monitor.sv
// checker for the power-state block, watching only its ports
// assumes one bus clock domain and an active-high async reset
`timescale 1ns/1ps
module lpsm_top_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // chipset request pins
  input wire logic clock_halt_request_n,
  input wire logic sleep_request_n,
  input wire logic sys_mgmt_irq_n,
  // core handshakes
  input wire logic save_done,
  input wire logic ack_accepted,
  // bus acknowledge request
  input wire logic ack_valid,
  input wire logic [1:0] ack_kind,
  // unit clock enables and service enables
  input wire logic [lpsm_pkg::GATE_W-1:0] unit_clk_en,
  input wire logic pll_run,
  input wire logic snoop_en,
  input wire logic intr_en,
  input wire logic exec_en,
  // smm sequencing
  input wire logic save_state_req,
  input wire logic sys_mgmt_mode,
  input wire logic smm_fetch_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_PLL_ALWAYS: assert property (
    pll_run)
    else $error("loop stopped");
  AST_GRANT_SERVICE: assert property (
    unit_clk_en == 3'h6 |-> snoop_en && intr_en && !exec_en)
    else $error("grant enables wrong");
  AST_SLEEP_QUIET: assert property (
    unit_clk_en == 3'h0 |-> !snoop_en && !intr_en)
    else $error("sleep still serves");
  AST_NO_RUN_SLEEP: assert property (
    $past(unit_clk_en) == 3'h7 |-> unit_clk_en != 3'h0)
    else $error("direct run to sleep");
  AST_GRANT_ACK: assert property (
    $past(unit_clk_en) == 3'h7 && unit_clk_en == 3'h6 |->
      ack_valid && ack_kind == lpsm_pkg::ACK_GRANT)
    else $error("no grant ack on entry");
  AST_HALT_IN: assert property (
    (!clock_halt_request_n && sleep_request_n) [*6] |->
      unit_clk_en == 3'h6)
    else $error("halt not entered");
  AST_HALT_OUT: assert property (
    clock_halt_request_n [*6] |-> unit_clk_en == 3'h7)
    else $error("clocks not restarted");
  AST_SMM_FETCH: assert property (
    ack_valid && ack_kind == lpsm_pkg::ACK_SMI && ack_accepted |->
      ##[1:2] smm_fetch_start && sys_mgmt_mode)
    else $error("no handler fetch");
  AST_SMM_SAVE: assert property (
    save_state_req |-> sys_mgmt_mode)
    else $error("save outside smm");
endmodule : lpsm_top_monitor

//--- tb/lpsm_chipset_model.sv
// chipset model driving the active-low request pins
// assumes the bench gives wanted levels; pins move on falling edges
`timescale 1ns/1ps
module lpsm_chipset_model (
  // bus clock, never used here
  input wire logic sys_clk,
  // wanted request levels from the bench, active high
  input wire logic halt,
  input wire logic slp,
  input wire logic smi,
  // active-low request pins toward the processor
  output logic clock_halt_request_n,
  output logic sleep_request_n,
  output logic sys_mgmt_irq_n
);
  // pins follow the bench levels at once, so they move on the falling edge
  // the bench drives on, mid-cycle for the rising edge; no race with the
  // bench and no alignment to the bus clock
  assign clock_halt_request_n = ~halt;
  assign sleep_request_n = ~slp;
  assign sys_mgmt_irq_n = ~smi;
endmodule : lpsm_chipset_model

//--- tb/lpsm_top_bench.sv
// bench for the power-state block with a chipset pin model
// assumes 50 MHz bus clock; inputs change on falling edges
`timescale 1ns/1ps
module lpsm_top_bench;
  logic sys_clk = 0, reset = 1, save_done = 0, ack_accepted = 0;
  logic halt = 0, slp = 0, smi = 0, halt_n, slp_n, smi_n, ack_valid;
  logic pll_run, snoop_en, intr_en, exec_en, save_state_req;
  logic sys_mgmt_mode, smm_fetch_start;
  logic [1:0] ack_kind;
  logic [lpsm_pkg::GATE_W-1:0] unit_clk_en;
  int error_cnt = 0, checks = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  lpsm_chipset_model i_cs (.sys_clk(sys_clk), .halt(halt), .slp(slp),
    .smi(smi), .clock_halt_request_n(halt_n), .sleep_request_n(slp_n),
    .sys_mgmt_irq_n(smi_n));
  lpsm_top i_dut (.sys_clk(sys_clk), .reset(reset),
    .clock_halt_request_n(halt_n), .sleep_request_n(slp_n),
    .sys_mgmt_irq_n(smi_n), .save_done(save_done),
    .ack_accepted(ack_accepted), .ack_valid(ack_valid), .ack_kind(ack_kind),
    .unit_clk_en(unit_clk_en), .pll_run(pll_run), .snoop_en(snoop_en),
    .intr_en(intr_en), .exec_en(exec_en), .save_state_req(save_state_req),
    .sys_mgmt_mode(sys_mgmt_mode), .smm_fetch_start(smm_fetch_start));
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // one accepted acknowledge, taken at a single rising edge
  task take_ack;
    ack_accepted = 1;
    wt(1);
    ack_accepted = 0;
  endtask : take_ack
  task finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // halt entry with ack, then release back to full run
  task t_halt;
    halt = 1;
    wt(6);
    chk({exec_en, unit_clk_en}, 8'h06);
    chk({ack_valid, ack_kind}, 8'h05);
    chk({snoop_en, intr_en}, 8'h03);
    take_ack();
    chk({ack_valid, ack_kind}, 8'h00);
    halt = 0;
    wt(6);
    chk({exec_en, unit_clk_en}, 8'h0f);
    $display("halt test done");
  endtask : t_halt
  // halt released before its ack is taken: the pending ack is withdrawn
  task t_halt_drop;
    halt = 1'b1;
    wt(6);
    chk({ack_valid, ack_kind}, 8'h05);
    halt = 1'b0;
    wt(6);
    chk({ack_valid, ack_kind}, 8'h00);
    chk({exec_en, unit_clk_en}, 8'h0f);
    $display("halt drop test done");
  endtask : t_halt_drop
  // sleep refused in run, entered from grant, smm held off until exit
  task t_sleep_smm;
    slp = 1;
    wt(6);
    chk(unit_clk_en, 8'h07);
    halt = 1;
    wt(6);
    take_ack();
    wt(6);
    chk({snoop_en, intr_en, unit_clk_en}, 8'h00);
    chk(pll_run, 8'h01);
    smi = 1;
    wt(6);
    chk({save_state_req, sys_mgmt_mode}, 8'h00);
    slp = 0;
    wt(8);
    chk(unit_clk_en, 8'h06);
    chk({save_state_req, sys_mgmt_mode}, 8'h03);
    save_done = 1;
    wt(2);
    chk({ack_valid, ack_kind}, 8'h06);
    take_ack();
    wt(1);
    chk(smm_fetch_start, 8'h01);
    wt(1);
    chk(smm_fetch_start, 8'h00);
    chk(sys_mgmt_mode, 8'h01);
    {halt, smi, save_done} = 3'h0;
    wt(6);
    chk(unit_clk_en, 8'h07);
    $display("sleep and smm test done");
  endtask : t_sleep_smm
  // cycle ceiling well above the 73 or so cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    wt(4);
    reset = 0;
    t_halt();
    t_halt_drop();
    t_sleep_smm();
    finish_test();
  end
endmodule : lpsm_top_bench
bind lpsm_top lpsm_top_monitor i_mon (.sys_clk(sys_clk), .reset(reset),
  .clock_halt_request_n(clock_halt_request_n),
  .sleep_request_n(sleep_request_n), .sys_mgmt_irq_n(sys_mgmt_irq_n),
  .save_done(save_done), .ack_accepted(ack_accepted), .ack_valid(ack_valid),
  .ack_kind(ack_kind), .unit_clk_en(unit_clk_en), .pll_run(pll_run),
  .snoop_en(snoop_en), .intr_en(intr_en), .exec_en(exec_en),
  .save_state_req(save_state_req), .sys_mgmt_mode(sys_mgmt_mode),
  .smm_fetch_start(smm_fetch_start));
